//--- cbs_defs.svh
// constants for the bank switch sequencer: timing, field widths, reset values
`ifndef CBS_DEFS_SVH
`define CBS_DEFS_SVH

`define CBS_CLK_NS          20
`define CBS_DIGCLK_NS       1000
`define CBS_STROBE_NS       1000000
`define CBS_DIGCLK_CYC      ((`CBS_DIGCLK_NS + `CBS_CLK_NS - 1) / `CBS_CLK_NS)
`define CBS_STROBE_HALF_CYC ((`CBS_STROBE_NS / 2) / `CBS_CLK_NS)
`define CBS_ON_SHIFT        9
`define CBS_ON_W            4
`define CBS_OFF_W           3
`define CBS_CNT_W           16
`define CBS_DIV_W           32
`define CBS_FLAG_BANK_A     1'b1
`define CBS_FLAG_BANK_B     1'b0
`define CBS_FLAG_RST        1'b1

`endif

//--- cbs_eom_det.sv
// message tracker: busy from message start until a manchester violation
`include "cbs_defs.svh"
module cbs_eom_det import cbs_pkg::*; (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic msg_start,
  input  wire logic half_valid,
  input  wire logic half_level,
  output logic      msg_busy,
  output logic      eom_pulse
);
  logic busy_r, busy_nxt;
  logic phase_r, phase_nxt;
  logic first_r, first_nxt;
  logic eom_r, eom_nxt;

  always_comb begin
    busy_nxt  = busy_r;
    phase_nxt = phase_r;
    first_nxt = first_r;
    eom_nxt   = 1'b0;
    if (msg_start) begin
      busy_nxt  = 1'b1;
      phase_nxt = 1'b0;
    end else if (busy_r && half_valid) begin
      if (!phase_r) begin
        first_nxt = half_level;
        phase_nxt = 1'b1;
      end else begin
        phase_nxt = 1'b0;
        // equal halves is a code violation, i.e. end of message
        if (half_level == first_r) begin
          busy_nxt = 1'b0;
          eom_nxt  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_r  <= 1'b0;
      phase_r <= 1'b0;
      first_r <= 1'b0;
      eom_r   <= 1'b0;
    end else begin
      busy_r  <= busy_nxt;
      phase_r <= phase_nxt;
      first_r <= first_nxt;
      eom_r   <= eom_nxt;
    end
  end

  assign msg_busy  = busy_r;
  assign eom_pulse = eom_r;

  a_eom_violation: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (busy_r && half_valid && phase_r && half_level == first_r && !msg_start)
      |=> (!busy_r && eom_r))
    else $error("violation did not end the message");

  a_eom_valid_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (busy_r && half_valid && phase_r && half_level != first_r && !msg_start)
      |=> (busy_r && !eom_r))
    else $error("valid symbol ended the message");
endmodule // cbs_eom_det

//--- cbs_host_model.sv
// host controller model: enable bits, config select, spi strobes, wake pin
module cbs_host_model (
  input  wire logic clk_sys,
  output logic      bank_a_enable,
  output logic      bank_b_enable,
  output logic      strobe_osc_enable,
  output logic      config_select_n,
  output logic      spi_enable_n,
  output logic      spi_access,
  output logic      strobe_pin,
  output logic      strobe_pin_driven
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pin_lvl_r = 1'b0;
  logic toggle_r  = 1'b0;
  initial begin
    {bank_a_enable, bank_b_enable, strobe_osc_enable, spi_access} = 4'h0;
    {config_select_n, spi_enable_n, strobe_pin_driven} = 3'h7;
  end
  // released pin wanders, so a stale level never passes for a drive
  always @(negedge clk_sys) toggle_r <= ~toggle_r;
  assign strobe_pin = strobe_pin_driven ? pin_lvl_r : toggle_r;
  // never both banks here with a transmit setup: no transmit in this model
  task automatic cfg_open(input logic a, input logic b, input logic osc);
    @(negedge clk_sys);
    config_select_n <= 1'b0;
    bank_a_enable   <= a;
    bank_b_enable   <= b;
    strobe_osc_enable <= osc;
  endtask
  task automatic cfg_close();
    @(negedge clk_sys);
    config_select_n <= 1'b1;
  endtask
  task automatic commit(input logic a, input logic b, input logic osc);
    cfg_open(a, b, osc);
    cfg_close();
  endtask
  task automatic set_pin(input logic drv, input logic lvl);
    @(negedge clk_sys);
    strobe_pin_driven <= drv;
    pin_lvl_r <= lvl;
  endtask
  task automatic spi_poke();
    @(negedge clk_sys);
    spi_access <= 1'b1;
    @(negedge clk_sys);
    spi_access <= 1'b0;
  endtask
  task automatic wake();
    @(negedge clk_sys);
    {config_select_n, spi_enable_n} <= 2'h0;
    @(negedge clk_sys);
    {config_select_n, spi_enable_n} <= 2'h3;
  endtask
endmodule // cbs_host_model

//--- cbs_pkg.sv
// types shared by the bank switch sequencer files
package cbs_pkg;
  typedef enum logic [2:0] {
    CBS_OFF = 3'b001,
    CBS_A   = 3'b010,
    CBS_B   = 3'b100
  } cbs_state_t;
endpackage

//--- cbs_sequencer.sv
// bank switch sequencer: picks bank A/B configuration and receiver on/off
//
// Functional notes
// - Only B enable clear: bank A; A clear, B set: bank B; both: alternate.
// - Direct control: chosen bank takes effect when config select rises.
// - Bank A only, pin high: run bank A, flag reads 1.
// - Bank B only, pin high: run bank B, flag reads 0.
// - Wake pin held low always means OFF.
// - Message under way in state A or B holds that state until its end.
// - Pin control, both banks: flag inverts on each pin falling edge.
// - Both banks: any SPI access out of standby makes the next ON sequence start in A.
// - Driven pin overrides oscillator; undriven pin leaves oscillator in charge.
// - Oscillator control, both banks: flag inverts at end of each A/B period.
// - Pin forced high in oscillator control freezes bank at the flag.
// - State A on time from bank A count, state B from bank B count.
// - OFF period always taken from bank A off code.
// - Pin high: ON in flag's state until pin released and message ended.
// - Pin released from low while OFF: running OFF period completes first.
// - Stretched states do not shift the later schedule.
// - Standby: SPI deselected, receiver off, SPI access and messages ignored until both selects go low.
// - End of message is two equal NRZ half-bits, a code violation.
// - ON time is count times 512 digital clock periods after crystal start.
// - OFF time is N strobe periods plus min(half strobe, ON time).
`include "cbs_defs.svh"
module cbs_sequencer import cbs_pkg::*; #(
  parameter int DIGCLK_CYC      = `CBS_DIGCLK_CYC,
  parameter int STROBE_HALF_CYC = `CBS_STROBE_HALF_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  bank_a_enable,
  input  wire logic                  bank_b_enable,
  input  wire logic                  strobe_osc_enable,
  input  wire logic                  config_select_n,
  input  wire logic                  spi_enable_n,
  input  wire logic                  spi_access,
  input  wire logic                  low_voltage_standby,
  input  wire logic                  xtal_ready,
  input  wire logic                  strobe_pin,
  input  wire logic                  strobe_pin_driven,
  input  wire logic [`CBS_ON_W-1:0]  bank_a_on_time_count,
  input  wire logic [`CBS_ON_W-1:0]  bank_b_on_time_count,
  input  wire logic [`CBS_OFF_W-1:0] bank_a_off_time_code,
  input  wire logic                  msg_start,
  input  wire logic                  nrz_half_valid,
  input  wire logic                  nrz_half_level,
  output logic                       rx_on,
  output logic                       cfg_bank_a,
  output logic                       cfg_bank_b,
  output logic                       active_bank_flag,
  output logic                       spi_deselect,
  output logic                       msg_active,
  output logic                       end_of_message
);
  // on time in digital clock ticks: count * 512
  function automatic logic [`CBS_CNT_W-1:0] on_ticks(input logic [`CBS_ON_W-1:0] c);
    on_ticks = `CBS_CNT_W'(c) << `CBS_ON_SHIFT;
  endfunction

  // off periods in half strobe ticks: 2 * N, N = code + 1
  function automatic logic [`CBS_CNT_W-1:0] off_halves(input logic [`CBS_OFF_W-1:0] c);
    off_halves = (`CBS_CNT_W'(c) + `CBS_CNT_W'(1)) << 1;
  endfunction

  // state and flag group
  cbs_state_t state_r, state_nxt;
  logic       flag_r, flag_nxt;
  logic       en_a_r, en_a_nxt;
  logic       en_b_r, en_b_nxt;
  logic       conf_q_r, pin_q_r, both_q_r, commit_r;
  logic       standby_r, standby_nxt;
  // schedule group
  logic                  sched_on_r, sched_on_nxt;
  logic                  off_sub_r, off_sub_nxt;
  logic [`CBS_CNT_W-1:0] sched_cnt_r, sched_cnt_nxt;
  logic                  on_end;
  // divider group
  logic [`CBS_DIV_W-1:0] dig_cnt_r, dig_cnt_nxt;
  logic [`CBS_DIV_W-1:0] half_cnt_r, half_cnt_nxt;
  logic                  dig_tick, half_tick;
  // decoded conditions
  logic both, only_b, osc, forced_hi, forced_lo, on_req, hold, pin_fall;
  logic spi_hit, msg_busy, eom_pulse;

  assign both      = en_a_r & en_b_r;
  assign only_b    = en_b_r & ~en_a_r;
  assign osc       = strobe_osc_enable;
  // a driven pin overrides the oscillator; undriven leaves the timer in charge
  assign forced_hi = strobe_pin & (~osc | strobe_pin_driven);
  assign forced_lo = ~strobe_pin & (~osc | strobe_pin_driven);
  assign on_req    = osc ? (strobe_pin_driven ? strobe_pin : sched_on_r) : strobe_pin;
  assign hold      = msg_busy & (state_r != CBS_OFF);
  assign pin_fall  = pin_q_r & ~strobe_pin & ~osc;
  // access while in standby is ignored
  assign spi_hit   = spi_access & ~standby_r;
  assign dig_tick  = (dig_cnt_r == `CBS_DIV_W'(DIGCLK_CYC - 1));
  assign half_tick = (half_cnt_r == `CBS_DIV_W'(STROBE_HALF_CYC - 1));

  // dividers: digital clock free runs; strobe clock stops while pin is held low
  always_comb begin
    dig_cnt_nxt  = dig_tick ? '0 : dig_cnt_r + `CBS_DIV_W'(1);
    half_cnt_nxt = half_cnt_r;
    if (!osc || standby_r) begin
      half_cnt_nxt = '0;
    end else if (!forced_lo) begin
      half_cnt_nxt = half_tick ? '0 : half_cnt_r + `CBS_DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dig_cnt_r  <= '0;
      half_cnt_r <= '0;
    end else begin
      dig_cnt_r  <= dig_cnt_nxt;
      half_cnt_r <= half_cnt_nxt;
    end
  end

  // schedule runs on its own timebase, never waiting on the actual state
  always_comb begin
    sched_on_nxt  = sched_on_r;
    off_sub_nxt   = off_sub_r;
    sched_cnt_nxt = sched_cnt_r;
    on_end        = 1'b0;
    if (!osc || standby_r) begin
      sched_on_nxt  = 1'b1;
      off_sub_nxt   = 1'b0;
      sched_cnt_nxt = on_ticks(flag_r ? bank_a_on_time_count : bank_b_on_time_count);
    end else if (sched_on_r) begin
      // on time counts only once the crystal runs
      if (dig_tick && xtal_ready) begin
        if (sched_cnt_r <= `CBS_CNT_W'(1)) begin
          sched_on_nxt  = 1'b0;
          off_sub_nxt   = 1'b0;
          sched_cnt_nxt = off_halves(bank_a_off_time_code);
          on_end        = 1'b1;
        end else begin
          sched_cnt_nxt = sched_cnt_r - `CBS_CNT_W'(1);
        end
      end
    end else if (!forced_lo) begin
      // held low: strobe clock stopped, off period resumes on release
      if (!off_sub_r) begin
        if (half_tick) begin
          if (sched_cnt_r <= `CBS_CNT_W'(1)) begin
            off_sub_nxt   = 1'b1;
            sched_cnt_nxt = on_ticks(flag_r ? bank_a_on_time_count
                                            : bank_b_on_time_count);
          end else begin
            sched_cnt_nxt = sched_cnt_r - `CBS_CNT_W'(1);
          end
        end
      end else if (half_tick || sched_cnt_r == '0) begin
        // tail ends at half a strobe period or the on time, whichever first
        sched_on_nxt  = 1'b1;
        off_sub_nxt   = 1'b0;
        sched_cnt_nxt = on_ticks(flag_r ? bank_a_on_time_count
                                        : bank_b_on_time_count);
      end else if (dig_tick) begin
        sched_cnt_nxt = sched_cnt_r - `CBS_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sched_on_r  <= 1'b1;
      off_sub_r   <= 1'b0;
      sched_cnt_r <= '0;
    end else begin
      sched_on_r  <= sched_on_nxt;
      off_sub_r   <= off_sub_nxt;
      sched_cnt_r <= sched_cnt_nxt;
    end
  end

  // bank selection, flag, standby and the actual on/off state
  always_comb begin
    en_a_nxt    = en_a_r;
    en_b_nxt    = en_b_r;
    standby_nxt = standby_r;
    flag_nxt    = flag_r;
    state_nxt   = state_r;
    // new enables only take effect on leaving configuration mode
    if (config_select_n && !conf_q_r) begin
      en_a_nxt = bank_a_enable;
      en_b_nxt = bank_b_enable;
    end
    // entry wins over exit so a standby request is never lost
    if (low_voltage_standby) begin
      standby_nxt = 1'b1;
    end else if (!config_select_n && !spi_enable_n) begin
      standby_nxt = 1'b0;
    end
    // enable decode: B clear means A, A clear with B set means B
    if (!en_b_r) begin
      flag_nxt = `CBS_FLAG_BANK_A;
    end else if (only_b) begin
      flag_nxt = `CBS_FLAG_BANK_B;
    end else if (spi_hit || !both_q_r) begin
      flag_nxt = `CBS_FLAG_BANK_A;
    end else if (pin_fall) begin
      flag_nxt = ~flag_r;
    end else if (osc && on_end && !forced_hi) begin
      // forced high freezes the flag, hence the bank
      flag_nxt = ~flag_r;
    end
    // pin low means OFF regardless of mode or message
    if (standby_r || forced_lo) begin
      state_nxt = CBS_OFF;
    end else if (on_req || hold) begin
      // entering ON takes the flag's bank; a hold or forced high keeps it
      // a fresh commit reselects the bank even with the pin held high
      if (state_r == CBS_OFF || (commit_r && !hold) || !(hold || forced_hi)) begin
        state_nxt = (commit_r ? flag_nxt : flag_r) ? CBS_A : CBS_B;
      end
    end else begin
      state_nxt = CBS_OFF;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= CBS_OFF;
      flag_r    <= `CBS_FLAG_RST;
      en_a_r    <= 1'b0;
      en_b_r    <= 1'b0;
      conf_q_r  <= 1'b1;
      commit_r  <= 1'b0;
      pin_q_r   <= 1'b0;
      both_q_r  <= 1'b0;
      standby_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      flag_r    <= flag_nxt;
      en_a_r    <= en_a_nxt;
      en_b_r    <= en_b_nxt;
      conf_q_r  <= config_select_n;
      commit_r  <= config_select_n & ~conf_q_r;
      pin_q_r   <= strobe_pin;
      both_q_r  <= both;
      standby_r <= standby_nxt;
    end
  end

  // messages only start while receiving; start and halves are ignored in standby
  cbs_eom_det u_eom (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .msg_start  (msg_start & ~standby_r & (state_r != CBS_OFF)),
    .half_valid (nrz_half_valid & ~standby_r),
    .half_level (nrz_half_level),
    .msg_busy   (msg_busy),
    .eom_pulse  (eom_pulse)
  );

  assign rx_on            = (state_r != CBS_OFF);
  assign cfg_bank_a       = (state_r == CBS_A);
  assign cfg_bank_b       = (state_r == CBS_B);
  assign active_bank_flag = flag_r;
  assign spi_deselect     = standby_r;
  assign msg_active       = msg_busy;
  assign end_of_message   = eom_pulse;

  a_pin_low_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    forced_lo |=> (state_r == CBS_OFF))
    else $error("pin low did not turn the receiver off");

  a_bank_a_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!en_b_r && strobe_pin && !standby_r) |=> (active_bank_flag && !cfg_bank_b))
    else $error("bank A only but flag or state wrong");

  a_bank_b_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    only_b |=> !active_bank_flag)
    else $error("bank B only but flag not zero");

  a_pin_fall_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (both && both_q_r && pin_fall && !spi_hit) |=> (flag_r != $past(flag_r)))
    else $error("flag did not invert on pin falling edge");

  a_spi_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (both && spi_hit) |=> flag_r)
    else $error("access did not restart at state A");

  a_osc_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (both && both_q_r && osc && on_end && !forced_hi && !spi_hit && !pin_fall)
      |=> (flag_r != $past(flag_r)))
    else $error("flag did not invert at end of on period");

  a_msg_hold_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hold && !forced_lo && !standby_r) |=> (state_r == $past(state_r)))
    else $error("state changed during message reception");

  a_conf_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (config_select_n && !conf_q_r)
      |=> (en_a_r == $past(bank_a_enable) && en_b_r == $past(bank_b_enable)))
    else $error("bank enables not taken on leaving config mode");

  a_standby_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (standby_r && (config_select_n || spi_enable_n)) |=> (state_r == CBS_OFF && spi_deselect))
    else $error("standby not quiet");

  a_off_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (osc && !standby_r && !sched_on_r && forced_lo)
      |=> (sched_cnt_r == $past(sched_cnt_r) && !sched_on_r))
    else $error("off period advanced while pin held low");

  a_off_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    on_end |=> (sched_cnt_r == off_halves($past(bank_a_off_time_code)) && !off_sub_r))
    else $error("off period not loaded from bank A code");
endmodule // cbs_sequencer

//--- tb_top.sv
// self-checking bench for the bank switch sequencer
`include "cbs_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DCYC = 2;
  localparam int HCYC = 20;
  localparam int ON1  = 512 * DCYC;
  logic                   clk_sys = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   low_voltage_standby = 1'b0;
  logic                   xtal_ready = 1'b1;
  logic [`CBS_ON_W-1:0]   a_on = 4'h1;
  logic [`CBS_ON_W-1:0]   b_on = 4'h2;
  logic [`CBS_OFF_W-1:0]  off_code = 3'h0;
  logic                   msg_start = 1'b0;
  logic                   nrz_half_valid = 1'b0;
  logic                   nrz_half_level = 1'b0;
  logic                   bank_a_enable, bank_b_enable, strobe_osc_enable, config_select_n;
  logic                   spi_enable_n, spi_access, strobe_pin, strobe_pin_driven;
  logic                   rx_on, cfg_bank_a, cfg_bank_b, active_bank_flag;
  logic                   spi_deselect, msg_active, end_of_message;
  int                     mismatches = 0;
  int                     n_compared = 0;
  int                     cycles = 0;
  int                     n;
  logic                   seen;
  always #10 clk_sys = ~clk_sys;
  cbs_host_model host (.clk_sys(clk_sys), .bank_a_enable(bank_a_enable),
    .bank_b_enable(bank_b_enable), .strobe_osc_enable(strobe_osc_enable),
    .config_select_n(config_select_n), .spi_enable_n(spi_enable_n), .spi_access(spi_access),
    .strobe_pin(strobe_pin), .strobe_pin_driven(strobe_pin_driven));
  cbs_sequencer #(.DIGCLK_CYC(DCYC), .STROBE_HALF_CYC(HCYC)) dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .bank_a_enable(bank_a_enable), .bank_b_enable(bank_b_enable),
    .strobe_osc_enable(strobe_osc_enable), .config_select_n(config_select_n),
    .spi_enable_n(spi_enable_n), .spi_access(spi_access),
    .low_voltage_standby(low_voltage_standby), .xtal_ready(xtal_ready),
    .strobe_pin(strobe_pin), .strobe_pin_driven(strobe_pin_driven),
    .bank_a_on_time_count(a_on), .bank_b_on_time_count(b_on),
    .bank_a_off_time_code(off_code), .msg_start(msg_start),
    .nrz_half_valid(nrz_half_valid), .nrz_half_level(nrz_half_level), .rx_on(rx_on),
    .cfg_bank_a(cfg_bank_a), .cfg_bank_b(cfg_bank_b), .active_bank_flag(active_bank_flag),
    .spi_deselect(spi_deselect), .msg_active(msg_active), .end_of_message(end_of_message));
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ceiling sits well above the longest oscillator scenario
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v, input string what);
    n_compared++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic settle();
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic pin(input logic lvl);
    host.set_pin(1'b1, lvl);
    settle();
  endtask
  task automatic wait_rx(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (rx_on !== lvl && cnt < lim) begin
      @(negedge clk_sys);
      cnt++;
    end
    chk(rx_on, lvl, "rx_on wait");
  endtask
  task automatic pulse_msg();
    @(negedge clk_sys) msg_start <= 1'b1;
    @(negedge clk_sys) msg_start <= 1'b0;
  endtask
  task automatic half(input logic lvl);
    @(negedge clk_sys);
    nrz_half_valid <= 1'b1;
    nrz_half_level <= lvl;
    @(negedge clk_sys);
    nrz_half_valid <= 1'b0;
  endtask
  task automatic t_single();
    for (int a = 0; a < 2; a++) begin
      pin(1'b0);
      host.commit(a[0], 1'b0, 1'b0);
      pin(1'b1);
      chk({rx_on, cfg_bank_a, cfg_bank_b}, 3'h6, "bank A on");
      chk(active_bank_flag, `CBS_FLAG_BANK_A, "flag A");
      pin(1'b0);
      chk(rx_on, 1'b0, "pin low off");
    end
    host.commit(1'b0, 1'b1, 1'b0);
    pin(1'b1);
    chk({cfg_bank_a, cfg_bank_b}, 2'h1, "bank B on");
    chk(active_bank_flag, `CBS_FLAG_BANK_B, "flag B");
    pin(1'b0);
    host.cfg_open(1'b1, 1'b0, 1'b0);
    pin(1'b1);
    chk(cfg_bank_b, 1'b1, "bank held in config mode");
    // pin stays high: direct control, the commit alone must switch banks
    host.cfg_close();
    settle();
    chk(cfg_bank_a, 1'b1, "bank after config exit");
    pin(1'b0);
    $display("test single banks done");
  endtask
  task automatic t_toggle();
    host.commit(1'b1, 1'b1, 1'b0);
    settle();
    chk(active_bank_flag, 1'b1, "both entry flag");
    for (int i = 0; i < 4; i++) begin
      pin(1'b1);
      chk({cfg_bank_a, cfg_bank_b}, i[0] ? 2'h1 : 2'h2, "alternate bank");
      pin(1'b0);
      chk(active_bank_flag, i[0], "flag after fall");
    end
    pin(1'b1);
    pin(1'b0);
    host.spi_poke();
    settle();
    chk(active_bank_flag, 1'b1, "flag after spi");
    pin(1'b1);
    chk(cfg_bank_a, 1'b1, "state A after spi");
    pin(1'b0);
    $display("test pin toggle done");
  endtask
  task automatic t_msg();
    host.commit(1'b1, 1'b0, 1'b0);
    pin(1'b1);
    pulse_msg();
    settle();
    chk(msg_active, 1'b1, "message busy");
    half(1'b1);
    half(1'b0);
    half(1'b1);
    settle();
    chk({msg_active, end_of_message}, 2'h2, "data pair no end");
    half(1'b1);
    n = 0;
    while (end_of_message !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    chk(end_of_message, 1'b1, "end pulse");
    @(negedge clk_sys);
    chk({msg_active, end_of_message}, 2'h0, "end pulse one cycle");
    pin(1'b0);
    $display("test message end done");
  endtask
  task automatic t_osc_msg();
    host.commit(1'b1, 1'b0, 1'b1);
    host.set_pin(1'b0, 1'b0);
    wait_rx(1'b1, 3000, n);
    pulse_msg(); // id burst taken as caught within this on period
    repeat (ON1 + 200) @(negedge clk_sys);
    chk({rx_on, cfg_bank_a}, 2'h3, "held by message");
    half(1'b0);
    half(1'b0);
    // fall comes at the end of the second scheduled on period, not shifted
    wait_rx(1'b0, ON1, n);
    chk(n >= ON1 - 200 && n <= ON1 - 120, 1'b1, "old timebase kept");
    $display("test oscillator message done");
  endtask
  task automatic t_osc_both();
    host.commit(1'b1, 1'b1, 1'b1);
    host.set_pin(1'b0, 1'b0);
    wait_rx(1'b1, 3000, n);
    chk(cfg_bank_a, 1'b1, "first state A");
    wait_rx(1'b0, 3000, n);
    chk(n >= ON1 - 8 && n <= ON1 + 8, 1'b1, "A on length");
    wait_rx(1'b1, 3000, n);
    chk(cfg_bank_b, 1'b1, "then state B");
    wait_rx(1'b0, 5000, n);
    chk(n >= 2 * ON1 - 8 && n <= 2 * ON1 + 8, 1'b1, "B on length");
    wait_rx(1'b1, 3000, n);
    chk(cfg_bank_a, 1'b1, "back to A");
    pin(1'b1);
    seen = cfg_bank_a;
    repeat (3000) @(negedge clk_sys);
    chk({rx_on, cfg_bank_a}, {1'b1, seen}, "frozen while forced");
    pin(1'b0);
    chk(rx_on, 1'b0, "forced low off");
    $display("test oscillator both done");
  endtask
  task automatic t_standby();
    host.commit(1'b1, 1'b0, 1'b0);
    pin(1'b1);
    @(negedge clk_sys) low_voltage_standby <= 1'b1;
    @(negedge clk_sys) low_voltage_standby <= 1'b0;
    settle();
    chk({spi_deselect, rx_on}, 2'h2, "standby entered");
    pulse_msg();
    settle();
    chk(msg_active, 1'b0, "message ignored");
    host.wake();
    settle();
    chk(spi_deselect, 1'b0, "standby left");
    pin(1'b0);
    $display("test standby done");
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n <= 1'b1;
    settle();
    chk({rx_on, active_bank_flag, spi_deselect}, 3'h2, "reset values");
    t_single();
    t_toggle();
    t_msg();
    t_osc_msg();
    t_osc_both();
    t_standby();
    results();
  end
endmodule // tb_top
